// ==== hdl/sei_pkg.sv ====
// Shared constants and types of the serial nonvolatile memory interface.
// Assumes one system clock at SYS_CLK_MHZ; all pins are asynchronous to it.
package sei_pkg;

  // ****************************************************************
  // Array geometry and timing
  // ****************************************************************
  localparam int ARRAY_BYTES = 512;
  localparam int ADDR_W = 9;
  localparam int PAGE_BYTES = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int SYS_CLK_MHZ = 25;
  // Self-timed write, in microseconds, and its length in system cycles
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * SYS_CLK_MHZ;
  localparam int BUSY_CNT_W = 17;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************************************
  // Opcodes and status layout
  // ****************************************************************
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_ARRAY_RD = 8'h03;
  localparam logic [7:0] OP_ARRAY_WR = 8'h02;
  localparam logic [7:0] OP_HIGH_MASK = 8'hf7;
  localparam int OP_HIGH_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_PROT_LO_BIT = 2;
  localparam int ST_PROT_HI_BIT = 3;
  localparam logic [7:0] ST_BUSY_VALUE = 8'hff;
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic [8:0] PROT_QTR_BASE = 9'h180;
  localparam logic [8:0] PROT_HALF_BASE = 9'h100;

  // Pin bundle: idle pin levels are deselected, not paused, not guarded
  typedef struct packed {
    logic select_n;
    logic serial_clk;
    logic serial_in;
    logic pause_n;
    logic write_guard_n;
  } sei_pins_t;
  localparam sei_pins_t PINS_IDLE = '{select_n: 1'b1, serial_clk: 1'b0, serial_in: 1'b0,
                                      pause_n: 1'b1, write_guard_n: 1'b1};
  // Synchroniser reset value: select reads low until the pin is seen high,
  // so a pin already low at reset release cannot pass for a falling edge
  localparam sei_pins_t PINS_RESET = '{select_n: 1'b0, serial_clk: 1'b0, serial_in: 1'b0,
                                       pause_n: 1'b1, write_guard_n: 1'b1};

  typedef enum logic [2:0] {
    PH_OPCODE   = 3'b000,
    PH_ADDR     = 3'b001,
    PH_DATA_IN  = 3'b010,
    PH_READ_OUT = 3'b011,
    PH_STAT_OUT = 3'b100,
    PH_STAT_IN  = 3'b101,
    PH_IGNORE   = 3'b110
  } sei_phase_t;

endpackage

// ==== hdl/sei_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes both sides run on the same clock as the owner.
`timescale 1ns/1ns
module sei_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("sei_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
  } sei_fifo_st_t;

  sei_fifo_st_t r_reg;
  sei_fifo_st_t r_next;
  logic push;
  logic pop;

  // ****************************************************************
  // Handshake and storage
  // ****************************************************************
  // Full and empty come straight from the count, so both are honest
  assign o_in_ready = (r_reg.count != (PW+1)'(DEPTH));
  assign o_out_valid = (r_reg.count != '0);
  assign o_out_data = r_reg.mem[r_reg.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr] = i_in_data;
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
    r_next.count = r_reg.count + (PW+1)'(push) - (PW+1)'(pop);
    // Flush wins: stale prefetched words must never reach the reader
    if (i_flush) begin
      r_next.wr = '0;
      r_next.rd = '0;
      r_next.count = '0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// ==== hdl/sei_core.sv ====
// Serial command interface of a 512 x 8 nonvolatile memory (device side).
// Assumes all pins are asynchronous and far slower than i_sys_clk.
// Contract
// - Capture input bits on serial clock rise.
// - Change serial output only after falling edge.
// - Deselected: output released, sequence reset.
// - Need select falling edge after power-up.
// - Guard low blocks all nonvolatile writes.
// - Guard falling while selected abandons write.
// - Pause freezes sequence, resumes same bit.
// - All fields shifted most significant first.
// - Stopped serial clock keeps all state.
// - Writes need latch; set/clear opcodes.
// - Latch clears at reset and write end.
// - Status readable always; fixed bit layout.
// - Busy flag; all bits one while busy.
// - Only status write changes protect bits.
// - Protect field guards quarter, half, all.
// - Decode status read and status write.
// - Array opcodes carry address high bit.
// - Sequential read with address increment.
// - Read address wraps at top to zero.
// - Accept idle-low and idle-high clock.
// - Write after set-latch in same selection ignored.
// - Page of four bytes, wraps within page.
// - Write starts only if select rises on byte edge.
`timescale 1ns/1ns
module sei_core #(
  parameter int WRITE_CYCLES = sei_pkg::WRITE_CYCLES,
  parameter int FIFO_DEPTH = sei_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_select_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic i_pause_n,
  input wire logic i_write_guard_n,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_write_busy
);

  generate
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << sei_pkg::BUSY_CNT_W)) begin : g_bad_wc
      $error("sei_core: WRITE_CYCLES out of counter range");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sei_pkg::sei_pins_t s1;
    sei_pkg::sei_pins_t s2;
    sei_pkg::sei_pins_t s3;
    sei_pkg::sei_pins_t pin;
    logic armed;
    sei_pkg::sei_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [8:0] addr;
    logic is_write;
    logic data_done;
    logic refuse;
    logic [sei_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    logic [sei_pkg::PAGE_BYTES-1:0] pvalid;
    logic [1:0] new_prot;
    logic write_latch_flag;
    logic [1:0] prot;
    logic busy;
    logic [sei_pkg::BUSY_CNT_W-1:0] busy_cnt;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic so;
    logic so_oe;
    logic [8:0] fetch_addr;
    logic fetch_en;
    logic [sei_pkg::ARRAY_BYTES-1:0][7:0] mem;
  } sei_state_t;

  sei_state_t r_reg;
  sei_state_t r_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic fifo_flush;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // True when the address falls in a segment the protect field covers
  function automatic logic sei_is_protected(input logic [8:0] a, input logic [1:0] p);
    logic hit;
    hit = 1'b0;
    case (p)
      2'h0: hit = 1'b0;
      2'h1: hit = (a >= sei_pkg::PROT_QTR_BASE);
      2'h2: hit = (a >= sei_pkg::PROT_HALF_BASE);
      2'h3: hit = 1'b1;
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Status byte; upper nibble reads as zero when idle
  function automatic logic [7:0] sei_status(input logic busy, input logic write_latch_flag,
                                            input logic [1:0] p);
    logic [7:0] s;
    s = 8'h00;
    if (busy) begin
      s = sei_pkg::ST_BUSY_VALUE;
    end else begin
      s[sei_pkg::ST_LATCH_BIT] = write_latch_flag;
      s[sei_pkg::ST_PROT_LO_BIT] = p[0];
      s[sei_pkg::ST_PROT_HI_BIT] = p[1];
    end
    return s;
  endfunction

  // ****************************************************************
  // Read prefetch buffer
  // ****************************************************************
  // Bytes are fetched ahead of the shifter; a stalled shifter fills the
  // buffer and its ready then holds the fetch address still.
  assign fifo_flush = (r_reg.phase != sei_pkg::PH_READ_OUT);

  sei_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_prefetch (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_flush(fifo_flush),
    .i_in_valid(r_reg.fetch_en),
    .o_in_ready(fifo_in_ready),
    .i_in_data(r_reg.mem[r_reg.fetch_addr]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [4:0] agree;
    logic sel;
    logic sel_rise;
    logic paused;
    logic clk_rise;
    logic clk_fall;
    logic byte_end;
    logic [7:0] sh;
    logic [7:0] ob;
    logic commit_ok;
    agree = '0;
    sel = 1'b0;
    sel_rise = 1'b0;
    paused = 1'b0;
    clk_rise = 1'b0;
    clk_fall = 1'b0;
    byte_end = 1'b0;
    sh = '0;
    ob = '0;
    commit_ok = 1'b0;
    r_next = r_reg;
    fifo_pop = 1'b0;

    // Three-stage pin synchroniser; a level is taken once stages two and three agree
    r_next.s1 = sei_pkg::sei_pins_t'({i_select_n, i_serial_clk, i_serial_in, i_pause_n,
                                      i_write_guard_n});
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.pin = sei_pkg::sei_pins_t'((r_reg.pin & ~agree) | (r_reg.s3 & agree));

    // Only a falling select after reset arms the device
    if (r_reg.pin.select_n && !r_next.pin.select_n) begin
      r_next.armed = 1'b1;
    end
    sel = r_next.armed && !r_next.pin.select_n;
    sel_rise = r_reg.armed && !r_reg.pin.select_n && r_next.pin.select_n;
    paused = !r_next.pin.pause_n;
    // Edges are seen in either idle polarity; both modes sample on the rise
    clk_rise = sel && !paused && !r_reg.pin.serial_clk && r_next.pin.serial_clk;
    clk_fall = sel && !paused && r_reg.pin.serial_clk && !r_next.pin.serial_clk;
    sh = {r_reg.shift_in[6:0], r_next.pin.serial_in};
    byte_end = (r_reg.bit_cnt == 3'd7);

    // Self-timed write countdown; the latch drops when the cycle completes
    if (r_reg.busy) begin
      if (r_reg.busy_cnt == '0) begin
        r_next.busy = 1'b0;
        r_next.write_latch_flag = 1'b0;
      end else begin
        r_next.busy_cnt = r_reg.busy_cnt - 1'b1;
      end
    end

    // Guard seen low at any time during a selection spoils its write
    if (sel && !r_next.pin.write_guard_n) begin
      r_next.refuse = 1'b1;
    end

    // Prefetch advances one address per accepted byte, wrapping at the top
    if (r_reg.fetch_en && fifo_in_ready) begin
      r_next.fetch_addr = r_reg.fetch_addr + 9'd1;
    end

    // Input bits are taken on the rising serial clock only
    if (clk_rise) begin
      r_next.shift_in = sh;
      r_next.bit_cnt = r_reg.bit_cnt + 3'd1;
      case (r_reg.phase)
        sei_pkg::PH_OPCODE: begin
          if (byte_end) begin
            // Only status read is served while a write cycle runs
            r_next.phase = sei_pkg::PH_IGNORE;
            if (sh == sei_pkg::OP_STATUS_RD) begin
              r_next.phase = sei_pkg::PH_STAT_OUT;
            end else if (!r_reg.busy) begin
              if (sh == sei_pkg::OP_SET_LATCH) begin
                r_next.write_latch_flag = 1'b1;
              end else if (sh == sei_pkg::OP_CLR_LATCH) begin
                r_next.write_latch_flag = 1'b0;
              end else if (sh == sei_pkg::OP_STATUS_WR) begin
                r_next.phase = sei_pkg::PH_STAT_IN;
              end else if ((sh & sei_pkg::OP_HIGH_MASK) == sei_pkg::OP_ARRAY_RD) begin
                r_next.phase = sei_pkg::PH_ADDR;
                r_next.addr[8] = sh[sei_pkg::OP_HIGH_BIT];
                r_next.is_write = 1'b0;
              end else if ((sh & sei_pkg::OP_HIGH_MASK) == sei_pkg::OP_ARRAY_WR) begin
                r_next.phase = sei_pkg::PH_ADDR;
                r_next.addr[8] = sh[sei_pkg::OP_HIGH_BIT];
                r_next.is_write = 1'b1;
              end
            end
          end
        end
        sei_pkg::PH_ADDR: begin
          if (byte_end) begin
            r_next.addr[7:0] = sh;
            if (r_reg.is_write) begin
              r_next.phase = sei_pkg::PH_DATA_IN;
            end else begin
              r_next.phase = sei_pkg::PH_READ_OUT;
              r_next.fetch_en = 1'b1;
              r_next.fetch_addr = {r_reg.addr[8], sh};
            end
          end
        end
        sei_pkg::PH_DATA_IN: begin
          // Completion is only true right after a byte's last bit
          r_next.data_done = byte_end;
          if (byte_end) begin
            r_next.pbuf[r_reg.addr[1:0]] = sh;
            r_next.pvalid[r_reg.addr[1:0]] = 1'b1;
            r_next.addr[1:0] = r_reg.addr[1:0] + 2'd1;
          end
        end
        sei_pkg::PH_STAT_IN: begin
          r_next.data_done = byte_end;
          if (byte_end) begin
            r_next.new_prot = {sh[sei_pkg::ST_PROT_HI_BIT], sh[sei_pkg::ST_PROT_LO_BIT]};
          end
        end
        default: begin
          r_next.phase = r_reg.phase;
        end
      endcase
    end

    // Output bits change on the falling serial clock only
    if (clk_fall && (r_reg.phase == sei_pkg::PH_READ_OUT ||
                     r_reg.phase == sei_pkg::PH_STAT_OUT)) begin
      r_next.out_cnt = r_reg.out_cnt + 3'd1;
      if (r_reg.out_cnt == 3'd0) begin
        if (r_reg.phase == sei_pkg::PH_READ_OUT) begin
          ob = fifo_out_data;
          fifo_pop = fifo_out_valid;
        end else begin
          ob = sei_status(r_reg.busy, r_reg.write_latch_flag, r_reg.prot);
        end
        r_next.so = ob[7];
        r_next.out_sh = {ob[6:0], 1'b0};
      end else begin
        r_next.so = r_reg.out_sh[7];
        r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
      end
    end

    // Output is driven only while selected and not paused
    r_next.so_oe = sel && !paused;

    // Rising select ends the sequence and may start a write cycle
    if (sel_rise) begin
      commit_ok = r_reg.data_done && r_reg.write_latch_flag && !r_reg.refuse && !r_reg.busy &&
                  r_reg.pin.write_guard_n;
      if (commit_ok && r_reg.phase == sei_pkg::PH_DATA_IN &&
          !sei_is_protected({r_reg.addr[8:2], 2'b00}, r_reg.prot)) begin
        for (int i = 0; i < sei_pkg::PAGE_BYTES; i++) begin
          if (r_reg.pvalid[i]) begin
            r_next.mem[{r_reg.addr[8:2], 2'(i)}] = r_reg.pbuf[i];
          end
        end
        r_next.busy = 1'b1;
        r_next.busy_cnt = sei_pkg::BUSY_CNT_W'(WRITE_CYCLES - 1);
      end else if (commit_ok && r_reg.phase == sei_pkg::PH_STAT_IN) begin
        r_next.prot = r_reg.new_prot;
        r_next.busy = 1'b1;
        r_next.busy_cnt = sei_pkg::BUSY_CNT_W'(WRITE_CYCLES - 1);
      end
    end

    // While deselected the phase, bit counts, done, refuse and write flags, page valid bits and fetch enable return to idle
    if (!sel) begin
      r_next.phase = sei_pkg::PH_OPCODE;
      r_next.bit_cnt = 3'd0;
      r_next.out_cnt = 3'd0;
      r_next.data_done = 1'b0;
      r_next.refuse = 1'b0;
      r_next.pvalid = '0;
      r_next.is_write = 1'b0;
      r_next.fetch_en = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Array and protect bits take erased/unprotected values on reset,
  // standing in for the nonvolatile contents of a fresh part.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.s1 <= sei_pkg::PINS_RESET;
      r_reg.s2 <= sei_pkg::PINS_RESET;
      r_reg.s3 <= sei_pkg::PINS_RESET;
      r_reg.pin <= sei_pkg::PINS_RESET;
      r_reg.phase <= sei_pkg::PH_OPCODE;
      r_reg.prot <= sei_pkg::PROT_RESET;
      r_reg.mem <= {sei_pkg::ARRAY_BYTES{sei_pkg::ERASED_BYTE}};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from state flip-flops
  assign o_serial_out = r_reg.so;
  assign o_serial_out_oe = r_reg.so_oe;
  assign o_write_busy = r_reg.busy;

endmodule

// ==== dv/sei_chk.sv ====
// Checker for the serial memory core, bound to its ports.
// Assumes pin levels stay at least 8 system cycles between changes.
`timescale 1ns/1ns
module sei_chk #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_select_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic i_pause_n,
  input wire logic i_write_guard_n,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic o_write_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ****************************************************************
  // Busy run length
  // ****************************************************************
  logic [19:0] busy_run_reg;
  logic [19:0] busy_run_next;
  // Counts consecutive busy cycles; cleared when idle
  always_comb begin
    busy_run_next = o_write_busy ? busy_run_reg + 20'h1 : 20'h0;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_run_reg <= 20'h0;
    end else begin
      busy_run_reg <= busy_run_next;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_oe_desel;
    i_select_n [*8] |-> !o_serial_out_oe;
  endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("output driven when idle");
  property p_oe_sel;
    $fell(i_select_n) && i_pause_n |-> ##[1:8] o_serial_out_oe;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output not enabled");
  property p_oe_pause;
    !i_pause_n [*8] |-> !o_serial_out_oe;
  endproperty
  a_oe_pause: assert property (p_oe_pause) else $error("output driven in pause");
  property p_oe_resume;
    $rose(i_pause_n) && !i_select_n |-> ##[1:8] o_serial_out_oe;
  endproperty
  a_oe_resume: assert property (p_oe_resume) else $error("no resume");
  // Latency after a falling clock is about 4 cycles, so the pin is still low
  property p_out_edge;
    o_serial_out_oe && $past(o_serial_out_oe) && $changed(o_serial_out)
      |-> !i_serial_clk && !$past(i_serial_clk, 3);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("output moved off fall");
  property p_busy_len;
    $fell(o_write_busy) |-> busy_run_reg >= WRITE_CYCLES - 1 && busy_run_reg <= WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_cause;
    $rose(o_write_busy) |-> i_select_n && $past(i_select_n, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy while selected");
  property p_busy_guard;
    $rose(o_write_busy) |-> $past(i_write_guard_n, 8);
  endproperty
  a_busy_guard: assert property (p_busy_guard) else $error("write under guard");
endmodule
bind sei_core sei_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_select_n(i_select_n),
  .i_serial_clk(i_serial_clk), .i_serial_in(i_serial_in), .i_pause_n(i_pause_n),
  .i_write_guard_n(i_write_guard_n), .o_serial_out(o_serial_out),
  .o_serial_out_oe(o_serial_out_oe), .o_write_busy(o_write_busy)
);

// ==== dv/sei_host.sv ====
// Host model: serial bus master driving the memory's pins.
// Assumes a free system clock; pins move 1 ns after its rising edge.
`timescale 1ns/1ns
module sei_host #(
  parameter int HALF = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_serial_out,
  output logic o_select_n,
  output logic o_serial_clk,
  output logic o_serial_in,
  output logic o_pause_n,
  output logic o_write_guard_n
);
  logic cpol = 1'b0;
  // Idle: deselected, clock parked low, no pause, writes allowed
  initial begin
    o_select_n = 1'b1;
    o_serial_clk = 1'b0;
    o_serial_in = 1'b0;
    o_pause_n = 1'b1;
    o_write_guard_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Idle clock level picks mode 0 or mode 3
  task automatic mode(input logic v);
    cpol = v;
    o_serial_clk = v;
    tick(HALF);
  endtask
  task automatic guard(input logic v);
    o_write_guard_n = v;
    tick(HALF);
  endtask
  // Each frame opens with a falling select
  task automatic start();
    o_serial_clk = cpol;
    tick(HALF);
    o_select_n = 1'b0;
    tick(HALF);
  endtask
  // Most significant bit first; the reply is sampled at each rise
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_serial_clk = 1'b0;
      o_serial_in = tx[7 - i];
      tick(HALF);
      rx = {rx[6:0], i_serial_out};
      o_serial_clk = 1'b1;
      tick(HALF);
    end
  endtask
  // Clock returns to idle before select rises; a write starts only at a byte edge
  task automatic stop();
    o_serial_clk = cpol;
    tick(HALF);
    o_select_n = 1'b1;
    tick(2 * HALF);
  endtask
  // Pause entered and left with the clock low; clock and data wiggle inside
  task automatic pause();
    o_serial_clk = 1'b0;
    tick(HALF);
    o_pause_n = 1'b0;
    tick(HALF);
    o_serial_clk = 1'b1;
    o_serial_in = ~o_serial_in;
    tick(HALF);
    o_serial_clk = 1'b0;
    tick(HALF);
    o_pause_n = 1'b1;
    tick(HALF);
  endtask
endmodule

// ==== dv/sei_core_tb.sv ====
// Testbench of the serial memory core driven by the host model.
// Assumes the checker binds itself to the core.
`timescale 1ns/1ns
module sei_core_tb;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
    logic [1:0] prot;
    logic guard_n;
    logic [7:0] exp;
  } sei_row_t;
  // Short write cycle, still long enough to read status while busy
  localparam int WCYC = 600;
  logic i_sys_clk;
  logic i_rst;
  logic sel_n;
  logic sck;
  logic si;
  logic pause_n;
  logic guard_n;
  logic so;
  logic so_oe;
  logic busy;
  // Released output shows the inverse of its last bit, so a late enable shows up
  logic so_pin;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] pg [4] = '{8'hc4, 8'hc5, 8'hc2, 8'hc3};
  sei_row_t rows [9] = '{
    '{9'h000, 8'h77, 2'h0, 1'b1, 8'h77}, '{9'h005, 8'h3c, 2'h0, 1'b1, 8'h3c},
    '{9'h17f, 8'ha5, 2'h1, 1'b1, 8'ha5}, '{9'h180, 8'h5a, 2'h1, 1'b1, 8'hff},
    '{9'h100, 8'h11, 2'h2, 1'b1, 8'hff}, '{9'h0ff, 8'h22, 2'h2, 1'b1, 8'h22},
    '{9'h000, 8'h33, 2'h3, 1'b1, 8'h77}, '{9'h1ff, 8'h44, 2'h0, 1'b0, 8'hff},
    '{9'h1ff, 8'h66, 2'h0, 1'b1, 8'h66}};
  initial i_sys_clk = 1'b0;
  always #20 i_sys_clk = ~i_sys_clk;
  assign so_pin = so_oe ? so : ~so;
  sei_core #(.WRITE_CYCLES(WCYC)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_select_n(sel_n), .i_serial_clk(sck),
    .i_serial_in(si), .i_pause_n(pause_n), .i_write_guard_n(guard_n),
    .o_serial_out(so), .o_serial_out_oe(so_oe), .o_write_busy(busy));
  sei_host host_u (
    .i_sys_clk(i_sys_clk), .i_serial_out(so_pin), .o_select_n(sel_n), .o_serial_clk(sck),
    .o_serial_in(si), .o_pause_n(pause_n), .o_write_guard_n(guard_n));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic op(input logic [7:0] c);
    host_u.start();
    host_u.bits(c, 8, d2);
  endtask
  task automatic status(input logic [7:0] exp);
    op(8'h05);
    host_u.bits(8'h00, 8, d);
    host_u.stop();
    chk(d, exp);
  endtask
  // Bounded wait; a stuck busy flag shows up as a mismatch
  task automatic wait_idle();
    for (int i = 0; i < 2 * WCYC && busy === 1'b1; i++) host_u.tick(1);
    chk({7'h0, busy}, 8'h00);
  endtask
  task automatic addr_op(input logic [7:0] c, input logic [8:0] a);
    op(c | {4'h0, a[8], 3'h0});
    host_u.bits(a[7:0], 8, d);
  endtask
  task automatic wr_status(input logic [1:0] p);
    op(8'h06);
    host_u.stop();
    op(8'h01);
    host_u.bits({4'h0, p, 2'h0}, 8, d);
    host_u.stop();
    wait_idle();
  endtask
  // Hang guard, about twice the expected run
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_rst = 1'b1;
    host_u.tick(20);
    chk({6'h0, so_oe, busy}, 8'h00);
    i_rst = 1'b0;
    host_u.tick(4);
    status(8'h00);
    $display("test reset done");
    foreach (rows[k]) begin
      wr_status(rows[k].prot);
      op(8'h06);
      host_u.stop();
      host_u.guard(rows[k].guard_n);
      addr_op(8'h02, rows[k].addr);
      host_u.bits(rows[k].data, 8, d);
      host_u.stop();
      host_u.guard(1'b1);
      wait_idle();
      addr_op(8'h03, rows[k].addr);
      host_u.bits(8'h00, 8, d);
      host_u.stop();
      chk(d, rows[k].exp);
      status({4'h0, rows[k].prot, rows[k].exp != rows[k].data, 1'b0});
      $display("test row %0d done", k);
    end
    // Read across the top of the array, clock parked between bytes
    addr_op(8'h03, 9'h1ff);
    host_u.bits(8'h00, 8, d);
    host_u.tick(60);
    host_u.bits(8'h00, 8, d2);
    host_u.stop();
    chk(d, 8'h66);
    chk(d2, 8'h77);
    $display("test wrap done");
    // Five bytes into a four-byte page; guard drops once the cycle runs
    op(8'h06);
    host_u.stop();
    addr_op(8'h02, 9'h011);
    for (int b = 1; b <= 5; b++) host_u.bits(8'hc0 + 8'(b), 8, d);
    host_u.stop();
    host_u.guard(1'b0);
    status(8'hff);
    chk({7'h0, busy}, 8'h01);
    host_u.guard(1'b1);
    wait_idle();
    addr_op(8'h03, 9'h010);
    foreach (pg[j]) begin
      host_u.bits(8'h00, 8, d);
      chk(d, pg[j]);
    end
    host_u.stop();
    status(8'h00);
    $display("test page done");
    // Write in the same frame as the latch command is lost
    op(8'h06);
    addr_op(8'h02, 9'h005);
    host_u.bits(8'h99, 8, d);
    host_u.stop();
    chk({7'h0, busy}, 8'h00);
    status(8'h02);
    // Select rising mid-byte abandons the write
    addr_op(8'h02, 9'h005);
    host_u.bits(8'h99, 4, d);
    host_u.stop();
    chk({7'h0, busy}, 8'h00);
    op(8'h04);
    host_u.stop();
    status(8'h00);
    $display("test refusals done");
    // Pause mid-byte, then finish the byte
    addr_op(8'h03, 9'h005);
    host_u.bits(8'h00, 4, d);
    host_u.pause();
    host_u.bits(8'h00, 4, d2);
    host_u.stop();
    chk({d[3:0], d2[3:0]}, 8'h3c);
    host_u.mode(1'b1);
    addr_op(8'h03, 9'h0ff);
    host_u.bits(8'h00, 8, d);
    host_u.stop();
    host_u.mode(1'b0);
    chk(d, 8'h22);
    $display("test pause and mode done");
    // Latch set, then a reset in mid-run with select held low; a set-latch
    // opcode sent before select rises and falls again must be ignored
    op(8'h06);
    host_u.stop();
    host_u.start();
    i_rst = 1'b1;
    host_u.tick(3);
    i_rst = 1'b0;
    host_u.tick(4);
    host_u.bits(8'h06, 8, d);
    host_u.stop();
    status(8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
